// ==== core/port3_ctrl.sv ====
// port 3 direction and function select registers with an axi4-lite slave
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ns
// How it works
// R1 - reset sets direction all ones, inputs
// R2 - direction bit 0 drives, 1 inputs
// R3 - direction word read/write as 16 bits
// R4 - upper direction half seen as byte
// R5 - direction halves accessible as separate bytes
// R6 - function bit selects port or alternate
// R7 - i2c bits only matter on i2c variants
// R8 - function word read/write as 16 bits
// R9 - upper function half seen as byte
// R10 - function halves accessible as separate bytes
// R11 - reset clears function select to zero
// R12 - unimplemented bits fixed, writes ignored
module port3_ctrl #(
    parameter bit HAS_I2C = 1'b1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [9:0] port_latch_in,
    input wire logic [9:0] alt_out,
    input wire logic [9:0] alt_oe,
    input wire logic [9:0] pin_in,
    output logic [9:0] pin_out,
    output logic [9:0] pin_oe,
    output logic [9:0] pin_value,
    output logic [9:0] alt_in
);
    logic [15:0] pin_direction_word_r;
    logic [15:0] pin_function_select_word_r;
    logic [15:0] dir_nxt;
    logic [15:0] fsel_nxt;
    logic [15:0] fsel_eff;
    port3_pkg::wr_state_t wr_state_r;
    port3_pkg::rd_state_t rd_state_r;
    logic aw_held_r;
    logic w_held_r;
    logic [31:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic do_write;
    port3_pkg::reg_sel_t wsel;

    // address decode shared by the read and write paths
    function automatic port3_pkg::reg_sel_t decode(input logic [31:0] addr);
        logic [29:0] w;
        w = addr[31:2];
        if (w == port3_pkg::DIR_WORD_ADDR[31:2])
            decode = port3_pkg::SEL_DIR_WORD;
        else if (w == port3_pkg::DIR_HIGH_ADDR[31:2])
            decode = port3_pkg::SEL_DIR_HIGH;
        else if (w == port3_pkg::FSEL_WORD_ADDR[31:2])
            decode = port3_pkg::SEL_FSEL_WORD;
        else if (w == port3_pkg::FSEL_HIGH_ADDR[31:2])
            decode = port3_pkg::SEL_FSEL_HIGH;
        else
            decode = port3_pkg::SEL_NONE;
    endfunction

    // merge a write into a 16-bit register: word view or high-byte view
    function automatic logic [15:0] merge(input logic [15:0] cur, input logic high_view,
                                          input logic [31:0] data, input logic [3:0] strb);
        logic [15:0] v;
        v = cur;
        if (high_view)
        begin
            if (strb[0])
                v[15:8] = data[7:0];
        end
        else
        begin
            if (strb[0])
                v[7:0] = data[7:0];
            if (strb[1])
                v[15:8] = data[15:8];
        end
        merge = v;
    endfunction

    assign wsel = decode(awaddr_r);
    assign do_write = (wr_state_r == port3_pkg::WR_COLLECT) && aw_held_r && w_held_r;

    // next register values; single-bit writes arrive as byte writes
    always_comb
    begin
        dir_nxt = pin_direction_word_r;
        fsel_nxt = pin_function_select_word_r;
        case (wsel)
            port3_pkg::SEL_DIR_WORD: dir_nxt = merge(dir_nxt, 1'b0, wdata_r, wstrb_r); // see R3
            port3_pkg::SEL_DIR_HIGH: dir_nxt = merge(dir_nxt, 1'b1, wdata_r, wstrb_r); // see R4
            port3_pkg::SEL_FSEL_WORD: fsel_nxt = merge(fsel_nxt, 1'b0, wdata_r, wstrb_r); // see R8
            port3_pkg::SEL_FSEL_HIGH: fsel_nxt = merge(fsel_nxt, 1'b1, wdata_r, wstrb_r); // see R9
            default:
            begin
                dir_nxt = pin_direction_word_r;
                fsel_nxt = pin_function_select_word_r;
            end
        endcase
        // unimplemented bits pinned regardless of what was written
        dir_nxt = dir_nxt | ~port3_pkg::IMPL_MASK; // see R12
        fsel_nxt = fsel_nxt & port3_pkg::IMPL_MASK; // see R12
    end

    // direction register; all pins start as inputs so nothing fights at power-up
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            pin_direction_word_r <= port3_pkg::DIR_RESET; // see R1
        else if (do_write)
            pin_direction_word_r <= dir_nxt; // see R5
    end

    // function select register; pins start in port mode
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            pin_function_select_word_r <= port3_pkg::FSEL_RESET; // see R11
        else if (do_write)
            pin_function_select_word_r <= fsel_nxt; // see R10
    end

    // i2c select bits are inert on variants without the bus
    assign fsel_eff = HAS_I2C ? pin_function_select_word_r
                              : (pin_function_select_word_r & ~port3_pkg::I2C_MASK); // see R7

    // write address channel; address and data may arrive in either order
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_held_r <= 1'b0;
            awaddr_r <= 32'h00000000;
            s_axi_awready <= 1'b1;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end
        else if (s_axi_bvalid && s_axi_bready)
        begin
            aw_held_r <= 1'b0;
            s_axi_awready <= 1'b1;
        end
    end

    // write data channel
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            w_held_r <= 1'b0;
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
            s_axi_wready <= 1'b1;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_held_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end
        else if (s_axi_bvalid && s_axi_bready)
        begin
            w_held_r <= 1'b0;
            s_axi_wready <= 1'b1;
        end
    end

    // write response; one write in flight keeps ordering trivial
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_state_r <= port3_pkg::WR_COLLECT;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= port3_pkg::RESP_OKAY;
        end
        else
        begin
            case (wr_state_r)
                port3_pkg::WR_COLLECT:
                    if (do_write)
                    begin
                        wr_state_r <= port3_pkg::WR_RESP;
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp <= (wsel == port3_pkg::SEL_NONE) ?
                                       port3_pkg::RESP_SLVERR : port3_pkg::RESP_OKAY;
                    end
                port3_pkg::WR_RESP:
                    if (s_axi_bready)
                    begin
                        wr_state_r <= port3_pkg::WR_COLLECT;
                        s_axi_bvalid <= 1'b0;
                    end
                default:
                    wr_state_r <= port3_pkg::WR_COLLECT;
            endcase
        end
    end

    // read channel; answer one cycle after the address is taken
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_state_r <= port3_pkg::RD_IDLE;
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= port3_pkg::RESP_OKAY;
        end
        else
        begin
            case (rd_state_r)
                port3_pkg::RD_IDLE:
                    if (s_axi_arvalid)
                    begin
                        rd_state_r <= port3_pkg::RD_DATA;
                        s_axi_arready <= 1'b0;
                        s_axi_rvalid <= 1'b1;
                        s_axi_rresp <= port3_pkg::RESP_OKAY;
                        case (decode(s_axi_araddr))
                            port3_pkg::SEL_DIR_WORD:
                                s_axi_rdata <= {16'h0000, pin_direction_word_r}; // see R3
                            port3_pkg::SEL_DIR_HIGH:
                                s_axi_rdata <= {24'h000000, pin_direction_word_r[15:8]}; // see R4
                            port3_pkg::SEL_FSEL_WORD:
                                s_axi_rdata <= {16'h0000, pin_function_select_word_r}; // see R8
                            port3_pkg::SEL_FSEL_HIGH:
                                s_axi_rdata <= {24'h000000,
                                                pin_function_select_word_r[15:8]}; // see R9
                            default:
                            begin
                                s_axi_rdata <= 32'h00000000;
                                s_axi_rresp <= port3_pkg::RESP_SLVERR;
                            end
                        endcase
                    end
                port3_pkg::RD_DATA:
                    if (s_axi_rready)
                    begin
                        rd_state_r <= port3_pkg::RD_IDLE;
                        s_axi_arready <= 1'b1;
                        s_axi_rvalid <= 1'b0;
                    end
                default:
                    rd_state_r <= port3_pkg::RD_IDLE;
            endcase
        end
    end

    // pin steering; outputs are registered inside the mux
    port3_pin_mux #(
        .WIDTH(port3_pkg::PIN_COUNT)
    ) u_pin_mux (
        .clk(clk),
        .rst_n(rst_n),
        .dir_bits(pin_direction_word_r[9:0]),
        .fsel_bits(fsel_eff[9:0]),
        .port_latch_in(port_latch_in),
        .alt_out(alt_out),
        .alt_oe(alt_oe),
        .pin_in(pin_in),
        .pin_out(pin_out),
        .pin_oe(pin_oe),
        .pin_value(pin_value),
        .alt_in(alt_in)
    );

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_dir_reset_ones: assert property ( // see R1
        $rose(rst_n) |-> pin_direction_word_r == 16'hFFFF)
        else $error("direction not all ones after reset");
    a_fsel_reset_zero: assert property ( // see R11
        $rose(rst_n) |-> pin_function_select_word_r == 16'h0000)
        else $error("function select not zero after reset");
    a_unimpl_bits_fixed: assert property ( // see R12
        (pin_direction_word_r & 16'hFCC0) == 16'hFCC0
        && (pin_function_select_word_r & 16'hFCC0) == 16'h0000)
        else $error("unimplemented bits changed");
    a_port_out_drive: assert property ( // see R2
        (fsel_eff[0] == 1'b0 && pin_direction_word_r[0] == 1'b0)
        ##1 $stable(pin_direction_word_r[0]) && $stable(fsel_eff[0]) |-> pin_oe[0])
        else $error("output-mode pin not driven");
    a_port_in_float: assert property ( // see R2
        (fsel_eff[3] == 1'b0 && pin_direction_word_r[3]) |=> !pin_oe[3])
        else $error("input-mode pin driven");
    a_dir_word_write: assert property ( // see R3
        do_write && wsel == port3_pkg::SEL_DIR_WORD && wstrb_r[1:0] == 2'h3
        |=> pin_direction_word_r == (($past(wdata_r[15:0]) & 16'h033F) | 16'hFCC0))
        else $error("direction word write lost");
    a_dir_high_write: assert property ( // see R4
        do_write && wsel == port3_pkg::SEL_DIR_HIGH && wstrb_r[0]
        |=> pin_direction_word_r[9:8] == $past(wdata_r[1:0])
            && $stable(pin_direction_word_r[7:0]))
        else $error("direction high byte write misplaced");
    a_dir_low_write: assert property ( // see R5
        do_write && wsel == port3_pkg::SEL_DIR_WORD && wstrb_r[1:0] == 2'h1
        |=> pin_direction_word_r[7:0] == ($past(wdata_r[7:0]) | 8'hC0)
            && $stable(pin_direction_word_r[15:8]))
        else $error("direction low byte write misplaced");
    a_fsel_high_write: assert property ( // see R9
        do_write && wsel == port3_pkg::SEL_FSEL_HIGH && wstrb_r[0]
        |=> pin_function_select_word_r[9:8] == $past(wdata_r[1:0]))
        else $error("function select high byte write misplaced");
    a_fsel_word_write: assert property ( // see R8
        do_write && wsel == port3_pkg::SEL_FSEL_WORD && wstrb_r[1:0] == 2'h3
        |=> pin_function_select_word_r == ($past(wdata_r[15:0]) & 16'h033F))
        else $error("function select word write lost");
    a_i2c_gate: assert property ( // see R7
        fsel_eff[9:8] == (HAS_I2C ? pin_function_select_word_r[9:8] : 2'h0))
        else $error("i2c select active on non-i2c variant");
    a_read_answer: assert property ( // bus timing, the design's own choice, not one of the listed rules
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid ##0 !s_axi_arready)
        else $error("read not answered in one cycle");
    a_write_answer: assert property ( // bus timing, the design's own choice, not one of the listed rules
        do_write |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
        else $error("write not answered in one cycle");
endmodule // port3_ctrl

// ==== core/port3_pkg.sv ====
// shared constants and types for the port 3 direction and function select block
package port3_pkg;
    // printed offsets are not all word multiples, so they are kept as indices
    localparam logic [31:0] DIR_WORD_IDX = 32'hFFFFF426;
    localparam logic [31:0] DIR_HIGH_IDX = 32'hFFFFF427;
    localparam logic [31:0] FSEL_WORD_IDX = 32'hFFFFF446;
    localparam logic [31:0] FSEL_HIGH_IDX = 32'hFFFFF447;
    // byte address is four times the index, cut to the 32-bit bus
    localparam logic [31:0] DIR_WORD_ADDR = {DIR_WORD_IDX[29:0], 2'h0};
    localparam logic [31:0] DIR_HIGH_ADDR = {DIR_HIGH_IDX[29:0], 2'h0};
    localparam logic [31:0] FSEL_WORD_ADDR = {FSEL_WORD_IDX[29:0], 2'h0};
    localparam logic [31:0] FSEL_HIGH_ADDR = {FSEL_HIGH_IDX[29:0], 2'h0};
    // reset values and implemented bits (pins 0 to 5, 8, 9)
    localparam logic [15:0] DIR_RESET = 16'hFFFF;
    localparam logic [15:0] FSEL_RESET = 16'h0000;
    localparam logic [15:0] IMPL_MASK = 16'h033F;
    localparam logic [15:0] I2C_MASK = 16'h0300;
    localparam int PIN_COUNT = 10;
    // open-drain pins are the two i2c lines
    localparam logic [9:0] OPEN_DRAIN_MASK = 10'h300;
    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [2:0] {
        SEL_NONE = 3'b000,
        SEL_DIR_WORD = 3'b001,
        SEL_DIR_HIGH = 3'b010,
        SEL_FSEL_WORD = 3'b011,
        SEL_FSEL_HIGH = 3'b100
    } reg_sel_t;
    typedef enum logic [0:0] {
        WR_COLLECT = 1'b0,
        WR_RESP = 1'b1
    } wr_state_t;
    typedef enum logic [0:0] {
        RD_IDLE = 1'b0,
        RD_DATA = 1'b1
    } rd_state_t;
endpackage

// ==== core/port3_pin_mux.sv ====
// per-pin steering between port logic and alternate functions
`timescale 1ns/1ns
module port3_pin_mux #(
    parameter int WIDTH = 10
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] dir_bits,
    input wire logic [WIDTH-1:0] fsel_bits,
    input wire logic [WIDTH-1:0] port_latch_in,
    input wire logic [WIDTH-1:0] alt_out,
    input wire logic [WIDTH-1:0] alt_oe,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_out,
    output logic [WIDTH-1:0] pin_oe,
    output logic [WIDTH-1:0] pin_value,
    output logic [WIDTH-1:0] alt_in
);
    logic [WIDTH-1:0] sync1_r;
    logic [WIDTH-1:0] sync2_r;
    logic [WIDTH-1:0] drive_nxt;
    logic [WIDTH-1:0] level_nxt;

    // two-stage synchroniser; first stage feeds only the second
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync1_r <= '0;
            sync2_r <= '0;
        end
        else
        begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
        end
    end

    // port mode: direction 0 drives latch; alternate mode: peripheral owns pin
    always_comb
    begin
        for (int i = 0; i < WIDTH; i++)
        begin
            if (fsel_bits[i])
            begin
                drive_nxt[i] = alt_oe[i];
                level_nxt[i] = alt_out[i];
            end
            else
            begin
                drive_nxt[i] = ~dir_bits[i]; // see R2
                level_nxt[i] = port_latch_in[i];
            end
        end
    end

    // open-drain lines only pull low, never drive high
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_oe <= '0;
            pin_out <= '0;
        end
        else
        begin
            pin_oe <= drive_nxt & ~(port3_pkg::OPEN_DRAIN_MASK & level_nxt);
            pin_out <= level_nxt & ~port3_pkg::OPEN_DRAIN_MASK;
        end
    end

    // peripherals see the pin only while they own it
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_value <= '0;
            alt_in <= '0;
        end
        else
        begin
            pin_value <= sync2_r;
            alt_in <= sync2_r & fsel_bits; // see R6
        end
    end
endmodule // port3_pin_mux

// ==== bench/port3_ctrl_bench.sv ====
// self-checking bench for the port 3 direction and function select block
`timescale 1ns/1ns
module port3_ctrl_bench;
    logic clk;
    logic rst_n;
    logic [31:0] s_axi_awaddr;
    logic [2:0] s_axi_awprot;
    logic s_axi_awvalid;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata;
    logic [3:0] s_axi_wstrb;
    logic s_axi_wvalid;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready;
    logic [31:0] s_axi_araddr;
    logic [2:0] s_axi_arprot;
    logic s_axi_arvalid;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready;
    logic [9:0] port_latch_in;
    logic [9:0] alt_out;
    logic [9:0] alt_oe;
    logic [9:0] pin_in;
    logic [9:0] pin_out;
    logic [9:0] pin_oe;
    logic [9:0] pin_value;
    logic [9:0] alt_in;
    int bad_count;
    int num_checks;

    port3_ctrl #(.HAS_I2C(1'b1)) u_port3_ctrl ( // i2c variant, bits 8,9 may be set
        .clk(clk), .rst_n(rst_n),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_awprot),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arprot(s_axi_arprot), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .port_latch_in(port_latch_in),
        .alt_out(alt_out), .alt_oe(alt_oe), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .pin_value(pin_value), .alt_in(alt_in)
    );

    // free-running 25 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // prints the verdict and stops the run
    task automatic close_out();
        if (bad_count == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // one compare for every kind of result, four-state exact
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // holds reset low for 16 edges; also used for a reset in mid-run
    task automatic do_reset();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
    endtask

    // address and data offered together, each dropped when its own ready is seen
    task automatic axi_write(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
                             output logic [1:0] resp);
        int n;
        bit done;
        n = 0;
        done = 0;
        resp = 2'h3;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!done && n < 200)
        begin
            @(posedge clk);
            n++;
            if (s_axi_awvalid === 1'b1 && s_axi_awready === 1'b1)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid === 1'b1 && s_axi_wready === 1'b1)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bready === 1'b1 && s_axi_bvalid === 1'b1)
            begin
                resp = s_axi_bresp;
                s_axi_bready <= 1'b0;
                done = 1;
            end
        end
        if (!done)
            check(32'h0, 32'h1, "write response never came");
    endtask

    // read: arvalid held until taken, rready held until rvalid sampled
    task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] resp);
        int n;
        bit done;
        n = 0;
        done = 0;
        d = 32'h0;
        resp = 2'h3;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!done && n < 200)
        begin
            @(posedge clk);
            n++;
            if (s_axi_arvalid === 1'b1 && s_axi_arready === 1'b1)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rready === 1'b1 && s_axi_rvalid === 1'b1)
            begin
                d = s_axi_rdata;
                resp = s_axi_rresp;
                s_axi_rready <= 1'b0;
                done = 1;
            end
        end
        if (!done)
            check(32'h0, 32'h1, "read data never came");
    endtask

    // write then check the answer code
    task automatic wr_ok(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
        logic [1:0] r;
        axi_write(a, d, s, r);
        check({30'h0, r}, {30'h0, port3_pkg::RESP_OKAY}, "write resp");
    endtask

    // read and compare against the expected word
    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp, input string what);
        logic [31:0] d;
        logic [1:0] r;
        axi_read(a, d, r);
        check({30'h0, r}, {30'h0, port3_pkg::RESP_OKAY}, "read resp");
        check(d, exp, what);
    endtask

    // pin outputs lag a register update by one edge; wait past it, then look
    task automatic pins_chk(input logic [9:0] oe, input logic [9:0] out);
        repeat (3) @(posedge clk);
        #1;
        check({22'h0, pin_oe}, {22'h0, oe}, "pin_oe");
        check({22'h0, pin_out}, {22'h0, out}, "pin_out");
    endtask

    // reset state of both registers in every view
    task automatic t_reset_values();
        rd_chk(port3_pkg::DIR_WORD_ADDR, {16'h0, port3_pkg::DIR_RESET}, "dir reset");
        rd_chk(port3_pkg::DIR_HIGH_ADDR, 32'h000000FF, "dir high reset");
        rd_chk(port3_pkg::FSEL_WORD_ADDR, 32'h00000000, "fsel reset");
        rd_chk(port3_pkg::FSEL_HIGH_ADDR, 32'h00000000, "fsel high reset");
        pins_chk(10'h000, 10'h000);
    endtask

    // word and byte views of direction, with output drive on the pins
    task automatic t_direction();
        port_latch_in <= 10'h1A5;
        wr_ok(port3_pkg::DIR_WORD_ADDR, 32'h00000000, 4'h3);
        rd_chk(port3_pkg::DIR_WORD_ADDR, 32'h0000FCC0, "dir word");
        // open-drain pins 8,9 drive only a low level; pins 6,7 still show the latch
        pins_chk(10'h23F, 10'h0A5);
        wr_ok(port3_pkg::DIR_HIGH_ADDR, 32'h00000002, 4'h1);
        rd_chk(port3_pkg::DIR_HIGH_ADDR, 32'h000000FE, "dir high byte");
        // lane 1 carries zeros but is not enabled, so upper half must survive
        wr_ok(port3_pkg::DIR_WORD_ADDR, 32'h0000000F, 4'h1);
        rd_chk(port3_pkg::DIR_WORD_ADDR, 32'h0000FECF, "dir low byte");
        pins_chk(10'h030, 10'h0A5);
        port_latch_in <= 10'h000;
        pins_chk(10'h130, 10'h000);
    endtask

    // function select in both views and its effect on the pins
    task automatic t_function();
        alt_oe <= 10'h3C5;
        alt_out <= 10'h1F0;
        pin_in <= 10'h2AA;
        wr_ok(port3_pkg::FSEL_WORD_ADDR, 32'h0000FFFF, 4'h3);
        rd_chk(port3_pkg::FSEL_WORD_ADDR, 32'h0000033F, "fsel word");
        rd_chk(port3_pkg::FSEL_HIGH_ADDR, 32'h00000003, "fsel high byte");
        pins_chk(10'h205, 10'h030);
        check({22'h0, pin_value}, 32'h000002AA, "pin_value");
        check({22'h0, alt_in}, 32'h0000022A, "alt_in");
        wr_ok(port3_pkg::FSEL_HIGH_ADDR, 32'h00000000, 4'h1);
        rd_chk(port3_pkg::FSEL_WORD_ADDR, 32'h0000003F, "fsel after high");
        // pin 8 back in port mode, output latch 0, so it pulls low
        pins_chk(10'h105, 10'h030);
    endtask

    // unmapped place refused, direction register untouched
    task automatic t_unmapped();
        logic [1:0] r;
        logic [31:0] d;
        axi_write(32'h00000010, 32'h00000000, 4'hF, r);
        check({30'h0, r}, {30'h0, port3_pkg::RESP_SLVERR}, "unmapped write resp");
        axi_read(32'h00000010, d, r);
        check({30'h0, r}, {30'h0, port3_pkg::RESP_SLVERR}, "unmapped read resp");
        check(d, 32'h00000000, "unmapped read data");
        rd_chk(port3_pkg::DIR_WORD_ADDR, 32'h0000FECF, "dir kept");
    endtask

    // main sequence
    initial
    begin
        bad_count = 0;
        num_checks = 0;
        rst_n = 1'b0;
        s_axi_awaddr = 32'h0;
        s_axi_awprot = 3'h0;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'h0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = 32'h0;
        s_axi_arprot = 3'h0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        port_latch_in = 10'h000;
        alt_out = 10'h000;
        alt_oe = 10'h000;
        pin_in = 10'h000;
        do_reset();
        t_reset_values();
        t_direction();
        t_unmapped();
        t_function();
        // second reset in mid-run must restore every value
        alt_oe <= 10'h000;
        do_reset();
        t_reset_values();
        close_out();
    end

    // watchdog: the sequence needs well under 2000 cycles
    initial
    begin
        repeat (20000) @(posedge clk);
        bad_count++;
        close_out();
    end
endmodule // port3_ctrl_bench
